// ===== hw/liu_jitter_irq_error_count_regs.sv
// register bank: attenuator setup, global interrupt enable/pending, pattern error counter
// assumes the serial control engine presents one-cycle read/write strobes with address and data
// on i_clk_sys; read data is valid the cycle after the read strobe
`timescale 1ns/1ps
module liu_jitter_irq_error_count_regs #(
  parameter int CNT_W = liu_regs_pkg::CNT_W
) (
  input  wire logic                              i_clk_sys,
  input  wire logic                              i_rst,
  input  wire logic [liu_regs_pkg::ADDR_W-1:0]   i_reg_addr,
  input  wire logic                              i_reg_wr,
  input  wire logic                              i_reg_rd,
  input  wire logic [liu_regs_pkg::DATA_W-1:0]   i_reg_wdata,
  input  wire logic                              i_pattern_test_enable,
  input  wire logic                              i_pattern_bit_error,
  input  wire logic                              i_irq_source_any,
  output logic      [liu_regs_pkg::DATA_W-1:0]   o_reg_rdata,
  output logic                                   o_jitter_enable,
  output logic                                   o_jitter_fifo_deep,
  output logic                                   o_jitter_path_select,
  output logic                                   o_jitter_fifo_pointer_clear,
  output logic                                   o_irq
);

  localparam int DW = liu_regs_pkg::DATA_W;

  // ***********************************
  // address decode
  // ***********************************
  function automatic logic hit(input logic [liu_regs_pkg::ADDR_W-1:0] a,
                               input logic [liu_regs_pkg::ADDR_W-1:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire sel_cfg  = hit(i_reg_addr, liu_regs_pkg::ADDR_JITTER_CONFIG);
  wire sel_en   = hit(i_reg_addr, liu_regs_pkg::ADDR_IRQ_ENABLE);
  wire sel_pend = hit(i_reg_addr, liu_regs_pkg::ADDR_IRQ_PENDING);
  wire sel_hi   = hit(i_reg_addr, liu_regs_pkg::ADDR_ERR_COUNT_HIGH);
  wire sel_lo   = hit(i_reg_addr, liu_regs_pkg::ADDR_ERR_COUNT_LOW);
  wire sel_hold = hit(i_reg_addr, liu_regs_pkg::ADDR_ERR_COUNT_HOLD);

  wire wr_cfg  = i_reg_wr && sel_cfg;
  wire wr_en   = i_reg_wr && sel_en;
  wire rd_hi   = i_reg_rd && sel_hi;
  wire rd_lo   = i_reg_rd && sel_lo;
  wire rd_cnt  = rd_hi || rd_lo;

  // ***********************************
  // configuration and enable registers
  // ***********************************
  logic [DW-1:0] cfg_q;
  logic [DW-1:0] cfg_d;
  logic          irq_en_q;
  logic          irq_en_d;
  logic          pend_q;

  // only defined config bits store; all other writes fall through
  assign cfg_d    = wr_cfg ? (i_reg_wdata & liu_regs_pkg::MASK_JITTER_CONFIG) : cfg_q;
  assign irq_en_d = wr_en ? i_reg_wdata[liu_regs_pkg::BIT_GLOBAL_IRQ_EN] : irq_en_q;

  wire mode_low  = cfg_d[liu_regs_pkg::BIT_JITTER_MODE_LOW];
  wire mode_high = cfg_d[liu_regs_pkg::BIT_JITTER_MODE_HIGH];
  wire ja_on_d   = !mode_low;
  wire ja_deep_d = !mode_low && mode_high;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cfg_q    <= liu_regs_pkg::RST_JITTER_CONFIG;
      irq_en_q <= liu_regs_pkg::RST_IRQ_ENABLE;
    end else begin
      cfg_q    <= cfg_d;
      irq_en_q <= irq_en_d;
    end
  end

  // outputs follow the next value so they line up with the stored register
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      // reset levels derived from the config reset value so the two never disagree
      o_jitter_enable             <= !liu_regs_pkg::RST_JITTER_CONFIG[liu_regs_pkg::BIT_JITTER_MODE_LOW];
      o_jitter_fifo_deep          <= liu_regs_pkg::RST_JITTER_CONFIG[liu_regs_pkg::BIT_JITTER_MODE_HIGH] &&
                                     !liu_regs_pkg::RST_JITTER_CONFIG[liu_regs_pkg::BIT_JITTER_MODE_LOW];
      o_jitter_path_select        <= liu_regs_pkg::RST_JITTER_CONFIG[liu_regs_pkg::BIT_JITTER_PATH];
      o_jitter_fifo_pointer_clear <= liu_regs_pkg::RST_JITTER_CONFIG[liu_regs_pkg::BIT_JITTER_PTR_CLEAR];
    end else begin
      o_jitter_enable             <= ja_on_d;
      o_jitter_fifo_deep          <= ja_deep_d;
      o_jitter_path_select        <= cfg_d[liu_regs_pkg::BIT_JITTER_PATH];
      o_jitter_fifo_pointer_clear <= cfg_d[liu_regs_pkg::BIT_JITTER_PTR_CLEAR];
    end
  end

  // ***********************************
  // global interrupt
  // ***********************************
  // pending shows service need even when masked, so software can poll
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      pend_q <= 1'b0;
      o_irq  <= 1'b0;
    end else begin
      pend_q <= i_irq_source_any;
      o_irq  <= i_irq_source_any && irq_en_d;
    end
  end

  // ***********************************
  // pattern error counter
  // ***********************************
  logic [CNT_W-1:0] count;
  logic [DW-1:0]    hold_q;
  logic [DW-1:0]    hold_d;
  wire              cnt_inc = i_pattern_test_enable && i_pattern_bit_error;
  wire [DW-1:0]     cnt_hi  = count[CNT_W-1 -: DW];
  wire [DW-1:0]     cnt_lo  = count[DW-1:0];

  sat_error_counter #(
    .WIDTH (CNT_W)
  ) u_err_cnt (
    .i_clk_sys (i_clk_sys),
    .i_rst     (i_rst),
    .i_inc     (cnt_inc),
    .i_clear   (rd_cnt),
    .o_count   (count)
  );

  // the unread byte is kept so the two halves form one snapshot
  assign hold_d = rd_hi ? cnt_lo : (rd_lo ? cnt_hi : hold_q);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hold_q <= liu_regs_pkg::READ_ZERO;
    end else begin
      hold_q <= hold_d;
    end
  end

  // ***********************************
  // read data
  // ***********************************
  wire [DW-1:0] cfg_rd  = cfg_q;
  wire [DW-1:0] en_rd   = {{(DW-1){1'b0}}, irq_en_q};
  wire [DW-1:0] pend_rd = {{(DW-1){1'b0}}, pend_q};
  // unmatched addresses, reserved ones included, read as zero
  wire [DW-1:0] rdata_d = sel_cfg  ? cfg_rd  :
                          sel_en   ? en_rd   :
                          sel_pend ? pend_rd :
                          sel_hi   ? cnt_hi  :
                          sel_lo   ? cnt_lo  :
                          sel_hold ? hold_q  :
                          liu_regs_pkg::READ_ZERO;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      o_reg_rdata <= liu_regs_pkg::READ_ZERO;
    end else if (i_reg_rd) begin
      o_reg_rdata <= rdata_d;
    end
  end

  // ***********************************
  // assertions
  // ***********************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  wire             known_addr = sel_cfg || sel_en || sel_pend || sel_hi || sel_lo || sel_hold;
  wire [CNT_W-1:0] cnt_max    = '1;

  sequence s_read_high;
    rd_hi && !cnt_inc;
  endsequence

  sequence s_read_low;
    rd_lo && !cnt_inc;
  endsequence

  a_mode_disable_decode: assert property (cfg_q[liu_regs_pkg::BIT_JITTER_MODE_LOW] |->
    !o_jitter_enable && !o_jitter_fifo_deep)
    else $error("attenuator not disabled by mode low bit");

  a_mode_deep_decode: assert property (wr_cfg |=>
    (o_jitter_fifo_deep == ($past(i_reg_wdata[liu_regs_pkg::BIT_JITTER_MODE_HIGH]) &&
                            !$past(i_reg_wdata[liu_regs_pkg::BIT_JITTER_MODE_LOW]))))
    else $error("attenuator depth decode wrong");

  // host leaves one idle cycle between a write and the following read
  a_cfg_write_stores: assert property (wr_cfg ##1 !wr_cfg ##1 (i_reg_rd && sel_cfg) |=>
    o_reg_rdata == ($past(i_reg_wdata, 3) & liu_regs_pkg::MASK_JITTER_CONFIG))
    else $error("config readback mismatch");

  a_path_select_follows: assert property (wr_cfg |=>
    o_jitter_path_select == $past(i_reg_wdata[1]))
    else $error("path select did not follow write");

  a_pointer_clear_set: assert property (wr_cfg && i_reg_wdata[3] |=> o_jitter_fifo_pointer_clear)
    else $error("pointer clear not driven");

  a_irq_masked_off: assert property (!irq_en_q && !wr_en |=> !o_irq)
    else $error("interrupt signalled while disabled");

  a_pending_readback: assert property (i_irq_source_any ##1 (i_reg_rd && sel_pend) |=>
    o_reg_rdata[0])
    else $error("pending bit not shown");

  a_high_read_snap: assert property (s_read_high |=>
    o_reg_rdata == $past(cnt_hi) && hold_q == $past(cnt_lo) && count == '0)
    else $error("high byte read snapshot wrong");

  a_low_read_snap: assert property (s_read_low |=>
    o_reg_rdata == $past(cnt_lo) && hold_q == $past(cnt_hi) && count == '0)
    else $error("low byte read snapshot wrong");

  a_read_keeps_event: assert property (rd_cnt && cnt_inc |=> count == 16'h0001)
    else $error("error lost at clear");

  a_count_increments: assert property (cnt_inc && !rd_cnt && count != cnt_max |=>
    count == $past(count) + 16'h0001)
    else $error("counter did not increment");

  a_reserved_zero: assert property (i_reg_rd && !known_addr |=> o_reg_rdata == 8'h00)
    else $error("reserved address returned data");

  a_count_saturates: assert property (count == cnt_max && !rd_cnt |=> count == cnt_max)
    else $error("counter wrapped");

endmodule

// ===== include/liu_regs_pkg.sv
// register map constants for the attenuator, global interrupt and pattern error counter bank
// assumes an 8-bit register port with a 6-bit register address decoded by the serial control engine
package liu_regs_pkg;

  // ***********************************
  // widths
  // ***********************************
  localparam int ADDR_W = 6;
  localparam int DATA_W = 8;
  localparam int CNT_W  = 16;

  // ***********************************
  // register offsets
  // ***********************************
  localparam logic [ADDR_W-1:0] ADDR_JITTER_CONFIG   = 6'h07;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE      = 6'h20;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_PENDING     = 6'h21;
  localparam logic [ADDR_W-1:0] ADDR_ERR_COUNT_HIGH  = 6'h30;
  localparam logic [ADDR_W-1:0] ADDR_ERR_COUNT_LOW   = 6'h31;
  localparam logic [ADDR_W-1:0] ADDR_ERR_COUNT_HOLD  = 6'h38;

  // ***********************************
  // field positions
  // ***********************************
  localparam int BIT_JITTER_MODE_LOW   = 0;
  localparam int BIT_JITTER_PATH       = 1;
  localparam int BIT_JITTER_MODE_HIGH  = 2;
  localparam int BIT_JITTER_PTR_CLEAR  = 3;
  localparam int BIT_GLOBAL_IRQ_EN     = 0;
  localparam int BIT_GLOBAL_IRQ_PEND   = 0;

  // ***********************************
  // reset values and masks
  // ***********************************
  localparam logic [DATA_W-1:0] RST_JITTER_CONFIG = 8'h00;
  localparam logic [DATA_W-1:0] MASK_JITTER_CONFIG = 8'h0f;
  localparam logic              RST_IRQ_ENABLE    = 1'b0;
  localparam logic [DATA_W-1:0] READ_ZERO         = 8'h00;
  localparam logic [CNT_W-1:0]  RST_ERR_COUNT     = 16'h0000;

endpackage

// ===== hw/sat_error_counter.sv
// saturating event counter with a synchronous clear
// assumes increment and clear come from logic on the same clock
`timescale 1ns/1ps
module sat_error_counter #(
  parameter int WIDTH = 16
) (
  input  wire logic             i_clk_sys,
  input  wire logic             i_rst,
  input  wire logic             i_inc,
  input  wire logic             i_clear,
  output logic [WIDTH-1:0]      o_count
);

  // ***********************************
  // count logic
  // ***********************************
  logic [WIDTH-1:0] count_q;
  logic [WIDTH-1:0] count_d;
  wire              at_max = &count_q;
  wire [WIDTH-1:0]  one    = {{(WIDTH-1){1'b0}}, 1'b1};

  // an error in the clearing cycle still counts: the count restarts at one
  assign count_d = i_clear ? (i_inc ? one : '0) :
                   (i_inc && !at_max) ? count_q + one : count_q;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

  assign o_count = count_q;

endmodule

// ===== bench/host_port_model.sv
// host side of the register port: one-cycle read and write strobes
// assumes one calling process and the bench clock; released write data and read address are driven inverted
`timescale 1ns/1ps
module host_port_model (
  input  wire logic                            i_clk_sys,
  input  wire logic [liu_regs_pkg::DATA_W-1:0] i_rdata,
  output logic      [liu_regs_pkg::ADDR_W-1:0] o_addr,
  output logic                                 o_wr,
  output logic                                 o_rd,
  output logic      [liu_regs_pkg::DATA_W-1:0] o_wdata
);
  // ***********************************
  // register port cycles
  // ***********************************
  initial begin
    o_addr  = 6'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
    o_wdata = 8'h00;
  end

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    #2;
    o_addr  = a;
    o_wdata = d;
    o_wr    = 1'b1;
    @(posedge i_clk_sys);
    #2;
    o_wr    = 1'b0;
    o_wdata = ~d;
  endtask

  // one-cycle read strobe; read data is taken just after the following clock edge
  task automatic rd_reg(input logic [5:0] a, output logic [7:0] d);
    @(posedge i_clk_sys);
    #2;
    o_addr = a;
    o_rd   = 1'b1;
    @(posedge i_clk_sys);
    #2;
    o_rd   = 1'b0;
    o_addr = ~a;
    d      = i_rdata;
  endtask
endmodule

// ===== bench/tb_liu_jitter_irq_error_count_regs.sv
// self-checking bench for the attenuator, interrupt and error counter register bank
// assumes the host port model drives the register port; model count kept in an int, other model state in logic vectors
`timescale 1ns/1ps
module tb_liu_jitter_irq_error_count_regs;
  logic       clk, rst, en, err, src, wr, rd, jen, jdeep, jpath, jptr, irq, ien_m, pend_m;
  logic [5:0] addr;
  logic [7:0] wdata, rdata, got, exp_rd, hold_m, rnd;
  logic [3:0] cfg_m;
  logic [5:0] rsv [8] = '{6'h08, 6'h22, 6'h2f, 6'h32, 6'h37, 6'h39, 6'h3d, 6'h3a};
  int         failures, n_checks, cnt_m, i;
  integer     seed = 98;

  host_port_model host (.i_clk_sys(clk), .i_rdata(rdata), .o_addr(addr), .o_wr(wr), .o_rd(rd), .o_wdata(wdata));

  liu_jitter_irq_error_count_regs dut (.i_clk_sys(clk), .i_rst(rst), .i_reg_addr(addr), .i_reg_wr(wr),
    .i_reg_rd(rd), .i_reg_wdata(wdata), .i_pattern_test_enable(en), .i_pattern_bit_error(err),
    .i_irq_source_any(src), .o_reg_rdata(rdata), .o_jitter_enable(jen), .o_jitter_fifo_deep(jdeep),
    .o_jitter_path_select(jpath), .o_jitter_fifo_pointer_clear(jptr), .o_irq(irq));

  // ***********************************
  // reference model
  // ***********************************
  function automatic logic [7:0] rd_val(input logic [5:0] a);
    case (a)
      6'h07: return {4'h0, cfg_m};
      6'h20: return {7'h00, ien_m};
      6'h21: return {7'h00, pend_m};
      6'h30: return cnt_m[15:8];
      6'h31: return cnt_m[7:0];
      6'h38: return hold_m;
      default: return 8'h00;
    endcase
  endfunction

  // a clearing read and a new error in one cycle leave a count of one
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_m = 4'h0;
      ien_m = 1'b0;
      pend_m = 1'b0;
      cnt_m = 0;
      hold_m = 8'h00;
    end else begin
      if (rd) exp_rd = rd_val(addr);
      if (rd && (addr == 6'h30 || addr == 6'h31)) begin
        hold_m = (addr == 6'h30) ? cnt_m[7:0] : cnt_m[15:8];
        cnt_m = en & err;
      end else if (en && err && cnt_m < 65535) cnt_m++;
      if (wr && addr == 6'h07) cfg_m = wdata[3:0];
      if (wr && addr == 6'h20) ien_m = wdata[0];
      pend_m = src;
    end
  end

  // ***********************************
  // checks and verdict
  // ***********************************
  task automatic check(input logic [7:0] g, input logic [7:0] e);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic rdcheck(input logic [5:0] a);
    host.rd_reg(a, got);
    check(got, exp_rd);
  endtask

  task automatic chk_cfg;
    check({4'h0, jptr, jpath, jdeep, jen}, {4'h0, cfg_m[3], cfg_m[1], ~cfg_m[0] & cfg_m[2], ~cfg_m[0]});
  endtask

  task automatic stop_test;
    if (failures == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // saturation run dominates: about 66k cycles
  initial begin
    #4000000;
    failures++;
    stop_test();
  end

  // ***********************************
  // scenarios
  // ***********************************
  initial begin
    rst = 1'b1;
    en = 1'b0;
    err = 1'b0;
    src = 1'b0;
    repeat (16) @(posedge clk);
    #2;
    rst = 1'b0;
    chk_cfg();
    rdcheck(6'h07);
    rdcheck(6'h20);
    rdcheck(6'h38);
    for (i = 0; i < 16; i++) begin
      rnd = $random(seed);
      host.wr_reg(6'h07, {rnd[7:4], i[3:0]});
      chk_cfg();
      rdcheck(6'h07);
    end
    for (i = 0; i < 10; i++) begin
      rnd = $random(seed);
      host.wr_reg((i < 8) ? rsv[i] : ((i == 8) ? 6'h21 : 6'h38), rnd);
      rdcheck((i < 8) ? rsv[i] : ((i == 8) ? 6'h21 : 6'h38));
    end
    chk_cfg();
    src = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    check({7'h00, irq}, 8'h00);
    rdcheck(6'h21);
    host.wr_reg(6'h20, 8'h01);
    rdcheck(6'h20);
    check({7'h00, irq}, 8'h01);
    src = 1'b0;
    repeat (2) @(posedge clk);
    #2;
    check({7'h00, irq}, 8'h00);
    rdcheck(6'h21);
    repeat (300) begin
      @(posedge clk);
      #2;
      rnd = $random(seed);
      en = rnd[0];
      err = rnd[1];
    end
    en = 1'b1;
    err = 1'b1;
    rdcheck(6'h30);
    en = 1'b0;
    err = 1'b0;
    rdcheck(6'h38);
    rdcheck(6'h31);
    rdcheck(6'h38);
    en = 1'b1;
    err = 1'b1;
    repeat (65600) @(posedge clk);
    #2;
    en = 1'b0;
    err = 1'b0;
    rdcheck(6'h31);
    rdcheck(6'h38);
    rdcheck(6'h30);
    stop_test();
  end
endmodule
